// File: design/ccp_capture_control.sv
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ccp_capture_control #(
    parameter int unsigned TIMER_W = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic pin_i,
    input wire logic pin_dir_i,
    input wire logic port_latch_i,
    input wire logic [TIMER_W-1:0] timer_value_i,
    input wire logic adc_enable_i,
    output logic timer_reset_o,
    output logic adc_start_o,
    output logic cmp_pin_o,
    output logic cmp_pin_oe_o,
    output logic irq_o
);
    import ccp_pkg::*;

    // The capture pair is two bytes, so only a 16-bit timer fits.
    if (TIMER_W != 16) begin : g_bad_width
        $error("TIMER_W must be 16");
    end

    // Control and data registers.
    logic [CTRL_IMPL_W-1:0] ctrl;
    logic [CTRL_IMPL_W-1:0] next_ctrl;
    logic [TIMER_W-1:0] cap_val;
    logic [TIMER_W-1:0] next_cap_val;
    logic [7:0] duty_high;
    logic [7:0] next_duty_high;
    logic flag;
    logic next_flag;
    logic enable;
    logic next_enable;
    logic cmp_out;
    logic next_cmp_out;
    logic match_q;
    logic next_match_q;
    logic next_timer_reset;
    logic next_adc_start;
    // Bus data phase state.
    logic dph_wr;
    logic next_dph_wr;
    logic [DEC_W-1:0] dph_addr;
    logic [DEC_W-1:0] next_dph_addr;
    logic [31:0] next_hrdata;
    // Decoded terms.
    logic [3:0] mode;
    logic aph;
    logic match;
    logic match_rise;
    logic flag_clr;
    logic [31:0] rd_word;
    // Pin synchroniser.
    logic pin_meta;
    logic pin_sync;

    ccp_edge_if ecap ();

    ccp_edge_unit u_edge (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .edge_bus(ecap)
    );

    // The pad is asynchronous; two flops before the edge logic sees it.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= pin_i;
            pin_sync <= pin_meta;
        end
    end

    // With the pin set as output the port latch is what the edge logic watches.
    assign mode = ctrl[CTRL_MODE_LSB +: MODE_W];
    assign ecap.mode = mode;
    assign ecap.level = pin_dir_i ? pin_sync : port_latch_i;

    // Zero wait state slave that never errors.
    assign hreadyout_o = 1'b1;
    assign hresp_o = HRESP_OKAY;
    assign irq_o = flag & enable;
    assign cmp_pin_o = cmp_out;
    assign cmp_pin_oe_o = drives_pin(mode);

    // Read mux; bits seven and six of the control word are not stored.
    always_comb begin
        rd_word = 32'h0000_0000;
        case (haddr_i[DEC_W-1:0])
            OFS_CTRL: begin
                rd_word[CTRL_IMPL_W-1:0] = ctrl;
            end
            OFS_CAP_LOW: begin
                rd_word[7:0] = cap_val[7:0];
            end
            OFS_CAP_HIGH: begin
                rd_word[7:0] = cap_val[15:8];
            end
            OFS_DUTY_HIGH: begin
                rd_word[7:0] = duty_high;
            end
            OFS_FLAG: begin
                rd_word[FLAG_BIT] = flag;
            end
            OFS_ENABLE: begin
                rd_word[FLAG_BIT] = enable;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // Next state of the bus, the registers and the compare logic.
    always_comb begin
        aph = hsel_i & htrans_i[1] & hready_i;
        next_dph_wr = aph & hwrite_i & (hsize_i == HSIZE_WORD);
        next_dph_addr = aph ? haddr_i[DEC_W-1:0] : dph_addr;
        next_hrdata = (aph & ~hwrite_i) ? rd_word : hrdata_o;
        next_ctrl = ctrl;
        next_cap_val = cap_val;
        next_duty_high = duty_high;
        next_enable = enable;
        flag_clr = 1'b0;
        if (dph_wr) begin
            case (dph_addr)
                OFS_CTRL: begin
                    next_ctrl = hwdata_i[CTRL_IMPL_W-1:0];
                end
                OFS_CAP_LOW: begin
                    next_cap_val[7:0] = hwdata_i[7:0];
                end
                OFS_CAP_HIGH: begin
                    next_cap_val[15:8] = hwdata_i[7:0];
                end
                OFS_DUTY_HIGH: begin
                    next_duty_high = hwdata_i[7:0];
                end
                OFS_FLAG: begin
                    flag_clr = hwdata_i[FLAG_BIT];
                end
                OFS_ENABLE: begin
                    next_enable = hwdata_i[FLAG_BIT];
                end
                default: begin
                    next_enable = enable;
                end
            endcase
        end
        // A capture beats a software write to the pair and overwrites unread data.
        if (ecap.capture) begin
            next_cap_val = timer_value_i;
        end
        // Flag on the first cycle of a match only; the timer may hold its value.
        match = is_compare(mode) && (timer_value_i == cap_val);
        match_rise = match & ~match_q;
        next_match_q = match;
        // Only software clears the flag, and a same-cycle event wins.
        next_flag = flag & ~flag_clr;
        if (ecap.capture || match_rise) begin
            next_flag = 1'b1;
        end
        // The duty low bits are stored but steer nothing in any mode.
        next_cmp_out = cmp_out;
        if (mode == MODE_OFF) begin
            next_cmp_out = 1'b0;
        end else if (match_rise) begin
            case (mode)
                MODE_CMP_SET: begin
                    next_cmp_out = 1'b1;
                end
                MODE_CMP_CLR: begin
                    next_cmp_out = 1'b0;
                end
                MODE_CMP_TOGGLE: begin
                    next_cmp_out = ~cmp_out;
                end
                default: begin
                    next_cmp_out = cmp_out;
                end
            endcase
        end
        // Special event: one-cycle timer reset and a gated conversion request.
        next_timer_reset = match_rise && (mode == MODE_CMP_SPECIAL);
        next_adc_start = next_timer_reset & adc_enable_i;
    end

    // Registers only.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ctrl <= CTRL_RST;
            cap_val <= '0;
            duty_high <= BYTE_RST;
            flag <= 1'b0;
            enable <= 1'b0;
            cmp_out <= 1'b0;
            match_q <= 1'b0;
            timer_reset_o <= 1'b0;
            adc_start_o <= 1'b0;
            dph_wr <= 1'b0;
            dph_addr <= '0;
            hrdata_o <= 32'h0000_0000;
        end else begin
            ctrl <= next_ctrl;
            cap_val <= next_cap_val;
            duty_high <= next_duty_high;
            flag <= next_flag;
            enable <= next_enable;
            cmp_out <= next_cmp_out;
            match_q <= next_match_q;
            timer_reset_o <= next_timer_reset;
            adc_start_o <= next_adc_start;
            dph_wr <= next_dph_wr;
            dph_addr <= next_dph_addr;
            hrdata_o <= next_hrdata;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_capture;
        ecap.capture;
    endsequence

    sequence s_swi_match;
        (mode == MODE_CMP_SWI) ##0 match_rise;
    endsequence

    sequence s_special_match;
        (mode == MODE_CMP_SPECIAL) ##0 match_rise;
    endsequence

    a_capture_copy: assert property (
        s_capture |=> cap_val == $past(timer_value_i))
        else $error("capture value not copied");
    a_capture_over: assert property (
        s_capture ##2 s_capture |=> cap_val == $past(timer_value_i))
        else $error("second capture not kept");
    a_flag_set: assert property (
        s_capture |=> flag)
        else $error("flag not set on capture");
    a_flag_sticky: assert property (
        flag && !flag_clr |=> flag)
        else $error("flag dropped without clear");
    a_port_capture: assert property (
        (mode == MODE_CAP_RISE) && !pin_dir_i && $past(!pin_dir_i) && $rose(port_latch_i)
        |-> ecap.capture ##1 flag)
        else $error("port write did not capture");
    a_swi_match: assert property (
        s_swi_match |=> flag && !cmp_pin_oe_o && $stable(cmp_out))
        else $error("software interrupt compare wrong");
    a_special_evt: assert property (
        s_special_match |=> timer_reset_o && (adc_start_o == $past(adc_enable_i)) && flag)
        else $error("special event wrong");
    a_off_reset: assert property (
        mode == MODE_OFF |-> !cmp_pin_oe_o ##1 !cmp_pin_o)
        else $error("off mode left pin state");
    a_ctrl_read: assert property (
        aph && !hwrite_i && (haddr_i[DEC_W-1:0] == OFS_CTRL) |=> hrdata_o[7:6] == 2'b00)
        else $error("control upper bits not zero");
endmodule // ccp_capture_control

// File: design/ccp_edge_unit.sv
`timescale 1ns/1ps
module ccp_edge_unit (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    ccp_edge_if.unit edge_bus
);
    import ccp_pkg::*;

    logic level_q;
    logic next_level_q;
    logic [PRE_W-1:0] pre_cnt;
    logic [PRE_W-1:0] next_pre_cnt;
    logic [PRE_W-1:0] pre_mask;
    logic rise;
    logic fall;

    // Edge detection runs in every mode, so a mode change cannot see an old edge as new.
    always_comb begin
        rise = edge_bus.level & ~level_q;
        fall = ~edge_bus.level & level_q;
        next_level_q = edge_bus.level;
        next_pre_cnt = pre_cnt;
        pre_mask = PRE16_MASK;
        edge_bus.capture = 1'b0;
        case (edge_bus.mode)
            MODE_CAP_FALL: begin
                edge_bus.capture = fall;
            end
            MODE_CAP_RISE: begin
                edge_bus.capture = rise;
            end
            MODE_CAP_RISE4, MODE_CAP_RISE16: begin
                if (edge_bus.mode == MODE_CAP_RISE4) begin
                    pre_mask = PRE4_MASK;
                end
                // The counter is shared by both dividers and is not cleared on a switch.
                if (rise) begin
                    next_pre_cnt = pre_cnt + 1'b1;
                    edge_bus.capture = (pre_cnt & pre_mask) == pre_mask;
                end
            end
            default: begin
                next_pre_cnt = '0;
            end
        endcase
    end

    // Registers only.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            level_q <= 1'b0;
            pre_cnt <= '0;
        end else begin
            level_q <= next_level_q;
            pre_cnt <= next_pre_cnt;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    a_fall_edge: assert property (
        (edge_bus.mode == MODE_CAP_FALL) && $fell(edge_bus.level) |-> edge_bus.capture)
        else $error("falling edge missed");
    a_rise_edge: assert property (
        (edge_bus.mode == MODE_CAP_RISE) && $rose(edge_bus.level) |-> edge_bus.capture)
        else $error("rising edge missed");
    a_quad_div: assert property (
        (edge_bus.mode == MODE_CAP_RISE4) && edge_bus.capture |-> rise && (pre_cnt[1:0] == 2'h3))
        else $error("divide by four wrong");
    a_sixteen_div: assert property (
        (edge_bus.mode == MODE_CAP_RISE16) && edge_bus.capture |-> rise && (pre_cnt == 4'hF))
        else $error("divide by sixteen wrong");
    a_prescale_clear: assert property (
        !is_capture(edge_bus.mode) |=> pre_cnt == '0)
        else $error("prescaler not cleared");
    a_prescale_keep: assert property (
        (edge_bus.mode == MODE_CAP_RISE4) ##1 ((edge_bus.mode == MODE_CAP_RISE16) && !rise)
        |=> pre_cnt == $past(pre_cnt))
        else $error("prescaler cleared on switch");
endmodule // ccp_edge_unit

// File: shared/ccp_edge_if.sv
`timescale 1ns/1ps
// Mode, sampled pin level and capture strobe between control and edge logic.
interface ccp_edge_if;
    import ccp_pkg::*;
    logic [MODE_W-1:0] mode;
    logic level;
    logic capture;
    modport unit (input mode, input level, output capture);
    modport ctl (output mode, output level, input capture);
endinterface

// File: shared/ccp_pkg.sv
// Function
// - Mode 0100 captures on every falling edge of the capture input.
// - Mode 0101 captures on every rising edge of the capture input.
// - Mode 0110 captures once per four rising edges.
// - Mode 0111 captures once per sixteen rising edges.
// - A capture copies the whole 16-bit timer value into the capture pair.
// - Every capture sets the unit event flag.
// - The event flag stays set until software clears it.
// - A new capture overwrites an unread captured value.
// - With the pin as output, a port latch change can cause a capture.
// - Changing the capture mode may raise a spurious event flag.
// - Prescale counter clears when off, outside capture, on reset; not on switching.
// - Mode 1010 sets the flag on match and leaves the pin alone.
// - Mode 1011 on match sets flag, resets timer, requests conversion if enabled.
package ccp_pkg;
    // Register byte offsets; only the low address bits are decoded.
    localparam int unsigned DEC_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CAP_LOW = 8'h04;
    localparam logic [7:0] OFS_CAP_HIGH = 8'h08;
    localparam logic [7:0] OFS_DUTY_HIGH = 8'h0C;
    localparam logic [7:0] OFS_FLAG = 8'h10;
    localparam logic [7:0] OFS_ENABLE = 8'h14;
    // Control register fields and reset values.
    localparam int unsigned MODE_W = 4;
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_DUTY_LSB = 4;
    localparam int unsigned CTRL_IMPL_W = 6;
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam int unsigned FLAG_BIT = 0;
    // Mode encodings.
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLR = 4'h9;
    localparam logic [3:0] MODE_CMP_SWI = 4'hA;
    localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;
    // Prescale counter width and divide masks.
    localparam int unsigned PRE_W = 4;
    localparam logic [3:0] PRE4_MASK = 4'h3;
    localparam logic [3:0] PRE16_MASK = 4'hF;
    // Bus constants.
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // Capture modes are 01xx.
    function automatic logic is_capture(input logic [3:0] m);
        return m[3:2] == 2'b01;
    endfunction

    // Compare modes are 0010 and 10xx.
    function automatic logic is_compare(input logic [3:0] m);
        return (m == MODE_CMP_TOGGLE) || (m[3:2] == 2'b10);
    endfunction

    // Only the toggle, set and clear compare modes take the pin.
    function automatic logic drives_pin(input logic [3:0] m);
        return (m == MODE_CMP_TOGGLE) || (m == MODE_CMP_SET) || (m == MODE_CMP_CLR);
    endfunction
endpackage

// File: test/ccp_capture_control_test.sv
`timescale 1ns/1ps
module ccp_capture_control_test;
    import ccp_pkg::*;
    logic clk_sys_i, rst_n_i, hsel, hwrite, hreadyout, hresp, pin, pin_dir, port_latch, adc_en;
    logic timer_rst, adc_start, cmp_pin, cmp_oe, irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [15:0] timer;
    logic [3:0] md;
    int bad_count, check_count, cnt, n_rst, n_adc;
    localparam logic [3:0] IDLE_MODES [4] = '{4'h0, 4'h1, 4'h3, 4'hC};

    // The capture pad comes from the far-side model.
    ccp_pin_model pin_u (.clk_sys_i(clk_sys_i), .pin_o(pin));

    // The only slave, so its ready is the bus ready.
    ccp_capture_control #(.TIMER_W(16)) dut_u (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
        .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata), .pin_i(pin), .pin_dir_i(pin_dir),
        .port_latch_i(port_latch), .timer_value_i(timer), .adc_enable_i(adc_en),
        .timer_reset_o(timer_rst), .adc_start_o(adc_start), .cmp_pin_o(cmp_pin),
        .cmp_pin_oe_o(cmp_oe), .irq_o(irq));

    // Free-running system clock.
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // Counts every comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One single word transfer; a slow slave is waited for at the end of each phase.
    task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= wr_en;
        hsize <= HSIZE_WORD;
        do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, exp);
    endtask

    // The capture pair is read as two bytes with no latching between them.
    task automatic cap_chk(input logic [15:0] exp);
        rd_chk(OFS_CAP_LOW, {24'h000000, exp[7:0]});
        rd_chk(OFS_CAP_HIGH, {24'h000000, exp[15:8]});
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        bad_count++;
        results();
    end

    // Main sequence; the timer is driven on this clock, so it changes synchronously.
    initial begin
        rst_n_i = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize = 3'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        pin_dir = 1'b1;
        port_latch = 1'b0;
        adc_en = 1'b0;
        timer = 16'h0000;
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_chk(OFS_CTRL, 32'h0);
        rd_chk(OFS_FLAG, 32'h0);
        chk({31'h0, irq}, 32'h0);
        chk({30'h0, hreadyout, hresp}, {30'h0, 1'b1, HRESP_OKAY});
        wr(OFS_CTRL, 32'hFF);
        rd_chk(OFS_CTRL, 32'h3F);
        wr(8'h20, 32'h5A);
        rd_chk(8'h20, 32'h0);
        $display("register test done");
        wr(OFS_CTRL, 32'h35);
        wr(OFS_FLAG, 32'h1);
        wr(OFS_ENABLE, 32'h1);
        timer <= 16'hA55A;
        pin_u.drive(1'b1, 6);
        timer <= 16'h0F0F;
        pin_u.drive(1'b0, 6);
        cap_chk(16'hA55A);
        timer <= 16'h1234;
        pin_u.drive(1'b1, 6);
        cap_chk(16'h1234);
        chk({31'h0, irq}, 32'h1);
        repeat (20) @(posedge clk_sys_i);
        rd_chk(OFS_FLAG, 32'h1);
        wr(OFS_ENABLE, 32'h0);
        // The mask lands at the edge that ends the write, so look one edge later.
        @(posedge clk_sys_i);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_FLAG, 32'h1);
        rd_chk(OFS_FLAG, 32'h0);
        $display("rising edge test done");
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, {28'h0, MODE_CAP_FALL});
        wr(OFS_FLAG, 32'h1);
        timer <= 16'hBEEF;
        pin_u.drive(1'b0, 6);
        timer <= 16'h4321;
        pin_u.drive(1'b1, 6);
        cap_chk(16'hBEEF);
        rd_chk(OFS_FLAG, 32'h1);
        wr(OFS_CTRL, 32'h0);
        pin_u.drive(1'b0, 4);
        $display("falling edge test done");
        // Two counted edges, then off and on again: the count must restart.
        for (int k = 0; k < 2; k++) begin
            md = (k == 0) ? MODE_CAP_RISE4 : MODE_CAP_RISE16;
            cnt = (k == 0) ? 4 : 16;
            wr(OFS_CTRL, {28'h0, md});
            pin_u.pulse(2);
            pin_u.pulse(2);
            wr(OFS_CTRL, 32'h0);
            wr(OFS_CTRL, {28'h0, md});
            wr(OFS_FLAG, 32'h1);
            for (int i = 1; i <= cnt; i++) begin
                timer <= i[15:0];
                pin_u.pulse(3);
                rd_chk(OFS_FLAG, {31'h0, i == cnt});
            end
            cap_chk(cnt[15:0]);
        end
        $display("prescale test done");
        wr(OFS_CTRL, {28'h0, MODE_CAP_RISE});
        pin_dir <= 1'b0;
        wr(OFS_FLAG, 32'h1);
        timer <= 16'h7E57;
        port_latch <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        cap_chk(16'h7E57);
        rd_chk(OFS_FLAG, 32'h1);
        // Two captures two cycles apart: the second replaces the first unread one.
        port_latch <= 1'b0;
        @(posedge clk_sys_i);
        port_latch <= 1'b1;
        timer <= 16'h1111;
        @(posedge clk_sys_i);
        port_latch <= 1'b0;
        timer <= 16'h2222;
        @(posedge clk_sys_i);
        port_latch <= 1'b1;
        timer <= 16'h3333;
        @(posedge clk_sys_i);
        port_latch <= 1'b0;
        @(posedge clk_sys_i);
        cap_chk(16'h3333);
        pin_dir <= 1'b1;
        $display("port latch test done");
        // Off, reserved and pulse-width modes ignore pad edges.
        foreach (IDLE_MODES[j]) begin
            wr(OFS_CTRL, {28'h0, IDLE_MODES[j]});
            wr(OFS_FLAG, 32'h1);
            pin_u.pulse(3);
            rd_chk(OFS_FLAG, 32'h0);
        end
        $display("idle mode test done");
        wr(OFS_CTRL, 32'h0);
        timer <= 16'h0000;
        wr(OFS_CAP_LOW, 32'h34);
        wr(OFS_CAP_HIGH, 32'h12);
        wr(OFS_CTRL, {28'h0, MODE_CMP_SWI});
        wr(OFS_FLAG, 32'h1);
        timer <= 16'h1234;
        repeat (3) @(posedge clk_sys_i);
        rd_chk(OFS_FLAG, 32'h1);
        chk({31'h0, cmp_oe}, 32'h0);
        // Special event with the converter on and then off.
        for (int e = 1; e >= 0; e--) begin
            timer <= 16'h0000;
            wr(OFS_CTRL, {28'h0, MODE_CMP_SPECIAL});
            wr(OFS_FLAG, 32'h1);
            adc_en <= e[0];
            timer <= 16'h1234;
            n_rst = 0;
            n_adc = 0;
            repeat (4) begin
                @(posedge clk_sys_i);
                #1;
                n_rst += int'(timer_rst === 1'b1);
                n_adc += int'(adc_start === 1'b1);
            end
            @(posedge clk_sys_i);
            chk(32'(n_rst), 32'h1);
            chk(32'(n_adc), 32'(e));
            chk({31'h0, cmp_oe}, 32'h0);
            rd_chk(OFS_FLAG, 32'h1);
        end
        // Set on match drives the latch high; turning the unit off forces it low.
        timer <= 16'h0000;
        wr(OFS_CTRL, {28'h0, MODE_CMP_SET});
        timer <= 16'h1234;
        repeat (3) @(posedge clk_sys_i);
        chk({30'h0, cmp_oe, cmp_pin}, 32'h3);
        wr(OFS_CTRL, 32'h0);
        repeat (2) @(posedge clk_sys_i);
        chk({30'h0, cmp_oe, cmp_pin}, 32'h0);
        $display("compare test done");
        results();
    end
endmodule // ccp_capture_control_test

// File: test/ccp_pin_model.sv
`timescale 1ns/1ps
// External source on the capture pad; it only moves just after a clock edge.
module ccp_pin_model (
    input wire logic clk_sys_i,
    output logic pin_o
);
    // Start low so that leaving reset shows no edge to the synchroniser.
    initial begin
        pin_o = 1'b0;
    end

    // Drive a level and keep it; a short hold is a fast source, a long one a slow source.
    task automatic drive(input logic level, input int hold);
        pin_o <= level;
        repeat (hold) @(posedge clk_sys_i);
    endtask

    // One rising edge followed by one falling edge.
    task automatic pulse(input int hold);
        drive(1'b1, hold);
        drive(1'b0, hold);
    endtask
endmodule // ccp_pin_model
